// File: src/hbt_trigger.sv
// Hardware breakpoint comparator and two-level trigger logic.
// Assumes register writes from the supervisor instruction and from the
// serial debugger are merged into one write port upstream, and that the
// program counter and local bus are sampled on the processor clock.
//
// Function
// [R1] Level 2 PC enable bit 17 includes the PC match in level 2.
// [R2] Level 2 PC invert bit 16 selects inside or outside region.
// [R3] Level 2 combine bit 15 selects AND or OR of PC and address/data.
// [R4] Level 1 combine bit 14 selects AND or OR of the terms.
// [R5] Level 1 global enable bit 13 gates every level 1 trigger.
// [R6] Bits 12 to 6 pick data lanes; all clear disables data matching.
// [R7] Data invert bit 5 inverts every data comparator result.
// [R8] Bits 4 to 2 select outside range, inside range, equal low bound.
// [R9] Bit 1 enables level 1 PC match; bit 0 inverts its region.
// [R10] The PC mask applies only to breakpoint 0.
// [R11] Extra PC breakpoints hold bits 31 to 1, used only when valid.
// [R12] Mask bit 0 compares, 1 ignores; software initialises the mask.
// [R13] Software writes breakpoint 0 bit 0 as zero.
// [R14] Software zero-fills the upper address byte.
// [R15] Address bounds compare every bus transfer, range inclusive.
// [R16] Data pattern compared with bus data; mask bit 1 ignores.
// [R17] Byte accesses at low bits 00, 01, 10 use lanes 31-24, 23-16, 15-8.
// [R18] Upper halfword configures level 2, lower halfword level 1; level 2 here uses bit 15 and the level 1 address/data term.
// [R19] Any trigger definition write clears trigger status bits.
// [R20] Software disables both levels before loading breakpoints.
// [R21] Level 2 evaluates only after level 1 has occurred.
// [R22] With no data lane enabled the data term counts as true.
// [R23] Breakpoint registers change only on a debug register write.
`timescale 1ns/1ps

module hbt_trigger #(
  parameter int EXTRA_PC_COUNT = 3
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Debug register write port
  input hbt_pkg::hbt_write_type reg_write,
  // Processor observation
  input wire logic pc_valid,
  input wire logic [31:0] pc,
  input hbt_pkg::hbt_bus_type bus,
  // Trigger results
  output logic level1_hit,
  output logic level1_armed,
  output logic trigger_fire,
  output logic [1:0] trigger_status_bits
);
  import hbt_pkg::*;

  // ****************************************************************
  // Reset synchroniser
  // ****************************************************************
  logic reset_meta_n;
  logic reset_sync_n;

  // Release is synchronised so every register leaves reset together.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reset_meta_n <= 1'b0;
      reset_sync_n <= 1'b0;
    end else begin
      reset_meta_n <= 1'b1;
      reset_sync_n <= reset_meta_n;
    end
  end

  // ****************************************************************
  // Breakpoint registers
  // ****************************************************************
  logic [31:0] trigger_definition;
  logic [31:0] pc_break_address_zero;
  logic [31:0] pc_break_mask;
  logic [31:0] address_break_low;
  logic [31:0] address_break_high;
  logic [31:0] data_break_pattern;
  logic [31:0] data_break_mask;
  logic [31:0] pc_break_address_extra [EXTRA_PC_COUNT];
  logic trig_def_write;

  assign trig_def_write = reg_write.valid &&
    reg_write.index == HBT_REG_TRIGGER_DEFINITION;

  // Registers change only on a write command; the hardware has no
  // interlock, so software must disable triggers while loading.
  always_ff @(posedge clock or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      trigger_definition <= HBT_REG_RESET;
      pc_break_address_zero <= HBT_REG_RESET;
      pc_break_mask <= HBT_REG_RESET;
      address_break_low <= HBT_REG_RESET;
      address_break_high <= HBT_REG_RESET;
      data_break_pattern <= HBT_REG_RESET;
      data_break_mask <= HBT_REG_RESET;
    end else if (reg_write.valid) begin // [R23] [R20]
      unique case (reg_write.index)
        HBT_REG_TRIGGER_DEFINITION: trigger_definition <= reg_write.data;
        HBT_REG_PC_BREAK_ADDRESS_ZERO: begin
          pc_break_address_zero <= reg_write.data; // [R13] [R14]
        end
        HBT_REG_PC_BREAK_MASK: pc_break_mask <= reg_write.data; // [R12]
        HBT_REG_ADDRESS_BREAK_LOW: address_break_low <= reg_write.data;
        HBT_REG_ADDRESS_BREAK_HIGH: address_break_high <= reg_write.data;
        HBT_REG_DATA_BREAK_PATTERN: data_break_pattern <= reg_write.data;
        HBT_REG_DATA_BREAK_MASK: data_break_mask <= reg_write.data;
        default: begin
        end
      endcase
    end
  end

  // Extra PC breakpoints sit at consecutive register numbers.
  for (genvar i = 0; i < EXTRA_PC_COUNT; i++) begin : g_extra
    always_ff @(posedge clock or negedge reset_sync_n) begin
      if (!reset_sync_n) begin
        pc_break_address_extra[i] <= HBT_REG_RESET;
      end else if (reg_write.valid && reg_write.index ==
                   HBT_REG_PC_BREAK_EXTRA_BASE + 5'(i)) begin // [R23]
        pc_break_address_extra[i] <= reg_write.data;
      end
    end
  end

  // ****************************************************************
  // Field decode
  // ****************************************************************
  logic l2_pc_enable;
  logic l2_pc_invert;
  logic l2_combine;
  logic l1_combine;
  logic l1_enable;
  logic [6:0] lane_enables;
  logic data_invert;
  logic [2:0] address_mode;
  logic l1_pc_enable;
  logic l1_pc_invert;

  // Bits 17 to 15 drive level 2, bits 14 to 0 level 1; level 2 shares the address/data term.
  // Field positions live in the package, so the monitor and the decode
  // here cannot drift apart when a field moves.
  assign l2_pc_enable = trigger_definition[HBT_L2_PC_ENABLE_BIT]; // [R18]
  assign l2_pc_invert = trigger_definition[HBT_L2_PC_INVERT_BIT];
  assign l2_combine = trigger_definition[HBT_L2_COMBINE_BIT];
  assign l1_combine = trigger_definition[HBT_L1_COMBINE_BIT];
  assign l1_enable = trigger_definition[HBT_L1_GLOBAL_ENABLE_BIT];
  assign lane_enables =
    trigger_definition[HBT_L1_DATA_LANE_HI:HBT_L1_DATA_LANE_LO];
  assign data_invert = trigger_definition[HBT_L1_DATA_INVERT_BIT];
  assign address_mode =
    trigger_definition[HBT_L1_ADDR_MODE_HI:HBT_L1_ADDR_MODE_LO];
  assign l1_pc_enable = trigger_definition[HBT_L1_PC_ENABLE_BIT];
  assign l1_pc_invert = trigger_definition[HBT_L1_PC_INVERT_BIT];

  // ****************************************************************
  // Program counter comparison
  // ****************************************************************
  logic [EXTRA_PC_COUNT-1:0] extra_hit;
  logic pc_zero_hit;
  logic pc_in_region;

  // Only breakpoint 0 is masked; a set mask bit ignores that bit.
  assign pc_zero_hit = ((pc ^ pc_break_address_zero) &
    ~pc_break_mask) == 32'h0000_0000; // [R10] [R12]

  for (genvar i = 0; i < EXTRA_PC_COUNT; i++) begin : g_pc_cmp
    assign extra_hit[i] = pc_break_address_extra[i][HBT_PC_VALID_BIT] &&
      pc[31:1] == pc_break_address_extra[i][31:1]; // [R11] [R10]
  end

  // Any enabled breakpoint places the program counter in the region.
  // A cleared valid flag keeps an unused extra breakpoint out of the sum.
  assign pc_in_region = pc_valid && (pc_zero_hit || (|extra_hit));

  // ****************************************************************
  // Address and data comparison
  // ****************************************************************
  logic addr_in_range;
  logic addr_hit;
  logic [3:0] byte_hit;
  logic [6:0] lane_hit;
  logic lane_allowed;
  logic data_term;
  logic addr_data_hit;

  // Range is inclusive of both bounds.
  assign addr_in_range = bus.address >= address_break_low &&
    bus.address <= address_break_high; // [R15]
  assign addr_hit = bus.valid && ((address_mode[2] && !addr_in_range) ||
    (address_mode[1] && addr_in_range) ||
    (address_mode[0] && bus.address == address_break_low)); // [R8]

  // Per-byte compare; byte 3 is lanes 31-24.
  for (genvar b = 0; b < 4; b++) begin : g_byte
    assign byte_hit[b] = ((bus.data[8*b +: 8] ^ data_break_pattern[8*b +: 8])
      & ~data_break_mask[8*b +: 8]) == 8'h00; // [R16]
  end

  // Lane order: long, lower word, upper word, bytes low to high.
  assign lane_hit = {byte_hit[3], byte_hit[2], byte_hit[1], byte_hit[0],
    &byte_hit[3:2], &byte_hit[1:0], &byte_hit};

  // A lane only counts when the access size and offset place the
  // operand there, so misaligned bytes pick the right lane.
  function automatic logic [6:0] hbt_lane_place(input logic [1:0] size,
                                                input logic [1:0] low);
    logic [6:0] place;
    place = 7'h00;
    unique case (size)
      HBT_SIZE_BYTE: place[6 - low] = 1'b1; // [R17]
      HBT_SIZE_WORD: place = low[1] ? 7'h02 : 7'h04;
      default: place = 7'h01;
    endcase
    return place;
  endfunction

  // Lane bits reordered so index 0 is the longword enable.
  logic [6:0] lane_sel;
  assign lane_sel = {lane_enables[0], lane_enables[1], lane_enables[2],
    lane_enables[3], lane_enables[4], lane_enables[5], lane_enables[6]};
  assign lane_allowed = |(lane_sel &
    hbt_lane_place(bus.size, bus.address[1:0])); // [R6]

  // Invert flips the comparator result; no lane enabled means the
  // data term does not restrict the address match.
  assign data_term = (lane_sel == 7'h00) ? 1'b1 :
    (lane_allowed && ((|(lane_sel & lane_hit & hbt_lane_place(bus.size,
    bus.address[1:0]))) ^ data_invert)); // [R22] [R7] [R6]
  // Data only ever qualifies an address match; it never fires alone.
  assign addr_data_hit = addr_hit && data_term;

  // ****************************************************************
  // Level combination
  // ****************************************************************
  logic l1_pc_cond;
  logic l2_pc_cond;
  logic next_level1_hit;
  logic next_level2_hit;

  // Each Program_counter_match carries its own enable, so a disabled term can
  // never fire on its own through the OR form.
  assign l1_pc_cond = l1_pc_enable && pc_valid &&
    (pc_in_region ^ l1_pc_invert); // [R9]
  assign l2_pc_cond = l2_pc_enable && pc_valid &&
    (pc_in_region ^ l2_pc_invert); // [R1] [R2]

  // A disabled PC term drops out of the OR and of the level 1 AND; the level 2 AND then never hits.
  always_comb begin
    if (l1_combine) begin
      next_level1_hit = l1_pc_cond || addr_data_hit; // [R4]
    end else if (l1_pc_enable) begin
      next_level1_hit = l1_pc_cond && (addr_data_hit ||
        address_mode == 3'h0);
    end else begin
      next_level1_hit = addr_data_hit;
    end
    next_level1_hit = next_level1_hit && l1_enable; // [R5]
    if (l2_combine) begin
      next_level2_hit = l2_pc_cond || addr_data_hit; // [R3]
    end else if (l2_pc_enable) begin
      next_level2_hit = l2_pc_cond && (addr_data_hit ||
        address_mode == 3'h0);
    end else begin
      next_level2_hit = 1'b0;
    end
  end

  // ****************************************************************
  // Two-level sequencing and status
  // ****************************************************************
  // Level 2 is looked at only once level 1 has fired; a two-level
  // trigger exists when any level 2 PC term is enabled.
  logic two_level;
  assign two_level = l2_pc_enable;

  always_ff @(posedge clock or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      level1_hit <= 1'b0;
      level1_armed <= 1'b0;
      trigger_fire <= 1'b0;
      trigger_status_bits <= 2'h0;
    end else begin
      level1_hit <= next_level1_hit;
      trigger_fire <= 1'b0;
      if (trig_def_write) begin
        level1_armed <= 1'b0;
        trigger_status_bits <= 2'h0; // [R19]
      end else if (!two_level && next_level1_hit) begin
        trigger_fire <= 1'b1;
        trigger_status_bits <= 2'h1;
      end else if (two_level && !level1_armed && next_level1_hit) begin
        level1_armed <= 1'b1; // [R21]
        trigger_status_bits <= 2'h1;
      end else if (two_level && level1_armed && next_level2_hit) begin
        level1_armed <= 1'b0;
        trigger_fire <= 1'b1;
        trigger_status_bits <= 2'h2;
      end
    end
  end

endmodule

// File: src/hbt_pkg.sv
// Package of the hardware breakpoint trigger block: register numbers,
// trigger definition field positions and the carrier types.
// Assumes a 32-bit debug register write port and a 32-bit local bus.
package hbt_pkg;

  // ****************************************************************
  // Debug register numbers
  // ****************************************************************
  localparam logic [4:0] HBT_REG_TRIGGER_DEFINITION = 5'h07;
  localparam logic [4:0] HBT_REG_PC_BREAK_ADDRESS_ZERO = 5'h08;
  localparam logic [4:0] HBT_REG_PC_BREAK_MASK = 5'h09;
  localparam logic [4:0] HBT_REG_ADDRESS_BREAK_LOW = 5'h0C;
  localparam logic [4:0] HBT_REG_ADDRESS_BREAK_HIGH = 5'h0D;
  localparam logic [4:0] HBT_REG_DATA_BREAK_PATTERN = 5'h0E;
  localparam logic [4:0] HBT_REG_DATA_BREAK_MASK = 5'h0F;
  localparam logic [4:0] HBT_REG_PC_BREAK_EXTRA_BASE = 5'h18;

  // ****************************************************************
  // Trigger definition field positions and reset values
  // ****************************************************************
  localparam int HBT_L2_PC_ENABLE_BIT = 17;
  localparam int HBT_L2_PC_INVERT_BIT = 16;
  localparam int HBT_L2_COMBINE_BIT = 15;
  localparam int HBT_L1_COMBINE_BIT = 14;
  localparam int HBT_L1_GLOBAL_ENABLE_BIT = 13;
  localparam int HBT_L1_DATA_LANE_HI = 12;
  localparam int HBT_L1_DATA_LANE_LO = 6;
  localparam int HBT_L1_DATA_INVERT_BIT = 5;
  localparam int HBT_L1_ADDR_MODE_HI = 4;
  localparam int HBT_L1_ADDR_MODE_LO = 2;
  localparam int HBT_L1_PC_ENABLE_BIT = 1;
  localparam int HBT_L1_PC_INVERT_BIT = 0;
  localparam int HBT_PC_VALID_BIT = 0;
  localparam logic [31:0] HBT_REG_RESET = 32'h0000_0000;

  // Debug register write command.
  typedef struct packed {
    logic valid;
    logic [4:0] index;
    logic [31:0] data;
  } hbt_write_type;

  // One local bus transfer, observed as it completes.
  typedef struct packed {
    logic valid;
    logic [1:0] size;
    logic [31:0] address;
    logic [31:0] data;
  } hbt_bus_type;

  localparam logic [1:0] HBT_SIZE_LONG = 2'h0;
  localparam logic [1:0] HBT_SIZE_BYTE = 2'h1;
  localparam logic [1:0] HBT_SIZE_WORD = 2'h2;

endpackage

// File: sim/hbt_trigger_monitor.sv
// Checker on the trigger block ports.
// Assumes it is bound into hbt_trigger, one clock domain.
`timescale 1ns/1ps
module hbt_trigger_monitor
  import hbt_pkg::*;
#(
  parameter int EXTRA_PC_COUNT = 3
) (
  // Clock and inputs
  input wire logic clock,
  input wire logic reset_n,
  input hbt_pkg::hbt_write_type reg_write,
  input wire logic pc_valid,
  input hbt_pkg::hbt_bus_type bus,
  // Results
  input wire logic level1_hit,
  input wire logic level1_armed,
  input wire logic trigger_fire,
  input wire logic [1:0] trigger_status_bits
);
  logic [31:0] trig_def_shadow;
  logic trig_def_wr;
  // Only a trigger definition write changes the gating.
  assign trig_def_wr = reg_write.valid &&
    reg_write.index == HBT_REG_TRIGGER_DEFINITION;
  // Shadow copy, so gating is judged without a view inside.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      trig_def_shadow <= HBT_REG_RESET;
    end else if (trig_def_wr) begin
      trig_def_shadow <= reg_write.data;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  sequence clr_s;
    trigger_status_bits == 2'h0 && !level1_armed;
  endsequence
  sequence arm_fire_s;
    level1_armed ##1 trigger_fire;
  endsequence
  chk_write_clears: assert property (
    trig_def_wr |=> clr_s) else $error("status kept after write");
  chk_idle_quiet: assert property (
    !bus.valid && !pc_valid |=> !level1_hit && !trigger_fire)
    else $error("hit without input");
  chk_l1_gated: assert property (
    !trig_def_shadow[HBT_L1_GLOBAL_ENABLE_BIT] |=> !level1_hit)
    else $error("hit while disabled");
  chk_arm_two_level: assert property (
    $rose(level1_armed) |-> $past(trig_def_shadow[HBT_L2_PC_ENABLE_BIT]))
    else $error("armed one level");
  chk_armed_status: assert property (
    level1_armed |-> trigger_status_bits == 2'h1)
    else $error("armed status wrong");
  chk_fire_disarms: assert property (
    arm_fire_s |-> !level1_armed && trigger_status_bits == 2'h2)
    else $error("fire kept armed");
  chk_one_level: assert property (
    !trig_def_shadow[HBT_L2_PC_ENABLE_BIT] && !trig_def_wr |=>
    trigger_fire == level1_hit) else $error("fire differs from hit");
  chk_status_legal: assert property (
    trigger_status_bits != 2'h3) else $error("illegal status");
endmodule
bind hbt_trigger hbt_trigger_monitor #(.EXTRA_PC_COUNT(EXTRA_PC_COUNT)) mon (
  .clock(clock), .reset_n(reset_n), .reg_write(reg_write),
  .pc_valid(pc_valid), .bus(bus), .level1_hit(level1_hit),
  .level1_armed(level1_armed), .trigger_fire(trigger_fire),
  .trigger_status_bits(trigger_status_bits));

// File: sim/hbt_partner_model.sv
// Processor core and debugger model driving the trigger block.
// Assumes the bench calls its tasks; changes land on falling edges.
`timescale 1ns/1ps
module hbt_partner_model
  import hbt_pkg::*;
(
  // Clock
  input wire logic clock,
  // Write port and processor observation
  output hbt_pkg::hbt_write_type reg_write,
  output logic pc_valid,
  output logic [31:0] pc,
  output hbt_pkg::hbt_bus_type bus
);
  // Quiet lines from time zero.
  initial begin
    reg_write = '0;
    pc_valid = 1'b0;
    pc = 32'h0;
    bus = '0;
  end
  // One word per strobe, held for one edge.
  task automatic wr(logic [4:0] i, logic [31:0] v);
    @(negedge clock);
    reg_write = {1'b1, i, v};
    @(negedge clock);
    reg_write.valid = 1'b0;
  endtask
  // One sample; released lines then carry inverted junk.
  task automatic obs(logic pv, logic [31:0] p, logic bv, logic [1:0] sz,
    logic [31:0] a, logic [31:0] d);
    @(negedge clock);
    pc_valid = pv;
    pc = p;
    bus = {bv, sz, a, d};
    @(negedge clock);
    pc_valid = 1'b0;
    pc = ~p;
    bus = {1'b0, ~sz, ~a, ~d};
  endtask
endmodule

// File: sim/hw_breakpoint_trigger_logic_tb_top.sv
// Self-checking bench for the breakpoint trigger block.
// Assumes the partner model drives every write and observation input on falling edges; the bench releases reset_n on one too.
`timescale 1ns/1ps
module hw_breakpoint_trigger_logic_tb_top;
  import hbt_pkg::*;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  hbt_write_type reg_write;
  hbt_bus_type bus;
  logic pc_valid, hit, armed, fire;
  logic [31:0] pc, lo, p0, pat;
  logic [1:0] status, m_st;
  logic [31:0] r [0:31];
  logic [31:0] ofs [4] = '{32'hFFFFFFFF, 32'h0, 32'h3F, 32'h40};
  logic [31:0] pcs [7] = '{32'h0, 32'h8, 32'h10, 32'h100, 32'h104, 32'h200,
    32'h180};
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  bit m_arm;
  // Processor clock, 40 ns period.
  always #20 clock = ~clock;
  hbt_partner_model pm (.clock(clock), .reg_write(reg_write),
    .pc_valid(pc_valid), .pc(pc), .bus(bus));
  hbt_trigger dut (.clock(clock), .reset_n(reset_n), .reg_write(reg_write),
    .pc_valid(pc_valid), .pc(pc), .bus(bus), .level1_hit(hit),
    .level1_armed(armed), .trigger_fire(fire), .trigger_status_bits(status));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // A hang is cut short well beyond the expected run length.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic cmp(string n, logic [1:0] e, logic [1:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic bit pcm(logic [31:0] p);
    bit m = ((p ^ r[8]) & ~r[9]) == 32'h0;
    for (int k = 24; k < 27; k++)
      m |= r[k][0] && r[k][31:1] == p[31:1];
    return m;
  endfunction
  // Bus lane that an operand of this size and offset occupies.
  function automatic logic [31:0] lane(int b, logic [1:0] sz, logic [1:0] o);
    if (b == 12) return sz == HBT_SIZE_LONG ? 32'hFFFFFFFF : 32'h0;
    if (b >= 10) return (sz == HBT_SIZE_WORD && o[1] == 1'(b - 10)) ?
      32'hFFFF0000 >> 16 * (b - 10) : 32'h0;
    return (sz == HBT_SIZE_BYTE && o == 2'(b - 6)) ?
      32'hFF000000 >> 8 * (b - 6) : 32'h0;
  endfunction
  function automatic bit adm(bit bv, logic [1:0] sz, logic [31:0] a,
    logic [31:0] d);
    bit ins = a >= r[12] && a <= r[13];
    bit am = r[7][4] && !ins || r[7][3] && ins || r[7][2] && a == r[12];
    bit dm = r[7][12:6] == 7'h0;
    logic [31:0] lm;
    for (int b = 6; b <= 12; b++) begin
      lm = lane(b, sz, a[1:0]);
      if (r[7][b] && lm != 32'h0)
        dm |= (((d ^ r[14]) & ~r[15] & lm) == 32'h0) ^ r[7][5];
    end
    return bv && am && dm;
  endfunction
  function automatic bit l1(bit pv, logic [31:0] p, bit ad);
    bit pt = pv && (pcm(p) ^ r[7][0]);
    if (!r[7][13]) return 1'b0;
    if (r[7][1] && r[7][4:2] != 3'h0) return r[7][14] ? pt || ad : pt && ad;
    return r[7][1] ? pt : ad;
  endfunction
  task automatic w(logic [4:0] i, logic [31:0] v);
    pm.wr(i, v);
    r[i] = v;
    if (i == HBT_REG_TRIGGER_DEFINITION) begin
      m_arm = 1'b0;
      m_st = 2'h0;
    end
  endtask
  // One observation, predicted first and then compared.
  task automatic run(bit pv, logic [31:0] p, bit bv, logic [1:0] sz,
    logic [31:0] a, logic [31:0] d);
    bit ad, h, f, p2;
    ad = adm(bv, sz, a, d);
    h = l1(pv, p, ad);
    p2 = pv && (pcm(p) ^ r[7][16]);
    f = r[7][17] ? m_arm && (r[7][15] ? p2 || ad : p2 && ad) : h;
    pm.obs(pv, p, bv, sz, a, d);
    cmp("level1_hit", 2'(h), 2'(hit));
    cmp("trigger_fire", 2'(f), 2'(fire));
    if (r[7][17]) begin
      m_st = f ? 2'h2 : h ? 2'h1 : m_st;
      m_arm = !f && (h || m_arm);
      cmp("level1_armed", 2'(m_arm), 2'(armed));
      cmp("status", m_st, status);
    end
  endtask
  initial begin
    pat = $urandom(32'h16d94c82);
    foreach (r[i]) r[i] = 32'h0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    reset_n = 1'b1;
    repeat (3) @(negedge clock);
    lo = $urandom & 32'h00FFF000 | 32'h100;
    p0 = $urandom & 32'h00FFFFF0;
    w(HBT_REG_PC_BREAK_MASK, 32'h0);
    w(HBT_REG_ADDRESS_BREAK_LOW, lo);
    w(HBT_REG_ADDRESS_BREAK_HIGH, lo + 32'h3F);
    w(5'h1F, 32'hFFFFFFFF);
    for (int m = 2; m <= 4; m++) begin
      w(HBT_REG_TRIGGER_DEFINITION, 32'h2000 | 32'h1 << m);
      foreach (ofs[k]) run(0, 0, 1, 0, lo + ofs[k], $urandom);
      run(0, 0, 0, 0, lo, 0);
    end
    w(HBT_REG_TRIGGER_DEFINITION, 32'h8);
    run(0, 0, 1, 0, lo, 0);
    $display("done address");
    w(HBT_REG_TRIGGER_DEFINITION, 32'h0);
    w(HBT_REG_PC_BREAK_ADDRESS_ZERO, p0);
    w(HBT_REG_PC_BREAK_MASK, 32'hF);
    w(5'h18, p0 + 32'h101);
    w(5'h19, p0 + 32'h200);
    w(5'h1A, p0 + 32'h181);
    for (int v = 0; v < 2; v++) begin
      w(HBT_REG_TRIGGER_DEFINITION, 32'h2002 | v);
      foreach (pcs[k]) run(1, p0 + pcs[k], 0, 0, 0, 0);
      run(0, p0, 0, 0, 0, 0);
    end
    for (int c = 0; c < 2; c++) begin
      w(HBT_REG_TRIGGER_DEFINITION, 32'h200A | c << 14);
      run(1, p0, 0, 0, 0, 0);
      run(0, p0, 1, 0, lo, 0);
      run(1, p0, 1, 0, lo, 0);
    end
    $display("done pc");
    w(HBT_REG_DATA_BREAK_PATTERN, pat);
    w(HBT_REG_DATA_BREAK_MASK, 32'h0F0F0F0F);
    for (int b = 6; b <= 12; b++) begin
      for (int i = 0; i < 2; i++) begin
        w(HBT_REG_TRIGGER_DEFINITION, 32'h2008 | 32'h1 << b | i << 5);
        for (int o = 0; o < 4; o++) run(0, 0, 1, 1, lo + o, pat);
        run(0, 0, 1, 2, lo + 2, pat ^ 32'h0F0F0F0F);
        run(0, 0, 1, 2, lo, pat ^ 32'h10000000);
        run(0, 0, 1, 0, lo, pat ^ $urandom);
      end
    end
    $display("done data");
    w(HBT_REG_TRIGGER_DEFINITION, 32'h22008);
    run(1, p0, 0, 0, 0, 0);
    run(0, 0, 1, 0, lo, 0);
    run(1, p0, 0, 0, 0, 0);
    run(1, p0, 1, 0, lo, 0);
    w(HBT_REG_TRIGGER_DEFINITION, 32'h3A008);
    run(0, 0, 1, 0, lo, 0);
    run(1, p0, 0, 0, 0, 0);
    run(1, p0 + 32'h10, 0, 0, 0, 0);
    run(0, 0, 1, 0, lo, 0);
    w(HBT_REG_TRIGGER_DEFINITION, 32'h3A008);
    run(0, 0, 0, 0, 0, 0);
    $display("done two level");
    complete_run();
  end
endmodule
